/* hw/serial_flash_sleep_pause_ctrl.sv */
// Deep sleep, pause pin and full-cycle clocking for a serial flash slave.
// Assumes pins arrive asynchronously and the SCK is well below sys_clk/4;
// busy_in and so_data_in come from core logic on sys_clk_in.
`timescale 1ns/1ps
module serial_flash_sleep_pause_ctrl
   import flash_sleep_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic cs_b_in,
   input wire logic sck_in,
   input wire logic si_in,
   input wire logic pause_b_in,
   input wire logic wp_b_in,
   input wire logic busy_in,
   input wire logic so_data_in,
   output logic so_out,
   output logic so_oe_out,
   output logic deep_sleep_out,
   output logic paused_out,
   output logic [7:0] cmd_byte_out,
   output logic cmd_valid_out,
   output logic abort_out,
   output logic write_enable_latch_clr_out,
   output logic wp_b_out
);
   logic [SYNC_W-1:0] pins_s;
   logic cs_s, sck_s, si_s, pause_s, wp_s;
   logic cs_prev_q, sck_prev_q;
   logic sck_rise, sck_fall, cs_rise, cs_act;
   logic paused_q, paused_d;
   logic [2:0] bit_cnt_q;
   logic byte_seen_q;
   logic [7:0] shift_q;
   logic [7:0] opcode_q;
   logic [TIMER_W-1:0] timer_q;
   power_state_type state_q;
   logic asleep;
   logic aligned;

   // Every pin crosses two flops before use; select idles high
   pin_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL(5'h1c)
   ) u_sync (
      .clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .async_in({cs_b_in, pause_b_in, wp_b_in, sck_in, si_in}),
      .sync_out(pins_s)
   );
   assign {cs_s, pause_s, wp_s, sck_s, si_s} = pins_s;

   // Edge history of the synchronised select and clock
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= cs_s;
         sck_prev_q <= sck_s;
      end
   end

   assign cs_act = ~cs_s;
   assign cs_rise = cs_s & ~cs_prev_q;
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign asleep = (state_q != ST_STANDBY);
   assign aligned = byte_seen_q && (bit_cnt_q == BYTE_BOUNDARY);

   // Pause only moves while SCK is low or on deselect; a change in the high phase waits
   always_comb begin
      paused_d = paused_q;
      if (!cs_act) begin
         paused_d = 1'b0;
      end else if (!sck_s) begin
         paused_d = ~pause_s;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         paused_q <= 1'b0;
      end else begin
         paused_q <= paused_d;
      end
   end

   // Input shifter; rising edges while paused are not counted
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_cnt_q <= 3'h0;
         byte_seen_q <= 1'b0;
         shift_q <= 8'h00;
         opcode_q <= 8'h00;
      end else if (!cs_act) begin
         bit_cnt_q <= 3'h0;
         byte_seen_q <= 1'b0;
      end else if (sck_rise && !paused_q) begin
         shift_q <= {shift_q[6:0], si_s};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7) begin
            byte_seen_q <= 1'b1;
            // Only the first byte is the opcode; trailing bits ignored
            if (!byte_seen_q) begin
               opcode_q <= {shift_q[6:0], si_s};
            end
         end
      end
   end

   // Opcode hand-off to the command core, blocked while asleep
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd_valid_out <= 1'b0;
         cmd_byte_out <= 8'h00;
      end else begin
         cmd_valid_out <= cs_act && sck_rise && !paused_q && !asleep
            && !byte_seen_q && (bit_cnt_q == 3'h7);
         if (cs_act && sck_rise && bit_cnt_q == 3'h7 && !byte_seen_q) begin
            cmd_byte_out <= {shift_q[6:0], si_s};
         end
      end
   end

   // Select released mid-pause aborts and drops the write latch
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         abort_out <= 1'b0;
         write_enable_latch_clr_out <= 1'b0;
      end else begin
         abort_out <= cs_rise && paused_q;
         write_enable_latch_clr_out <= cs_rise && paused_q;
      end
   end

   // Power state: commands act only at select release on a byte edge.
   // Busy only gates sleep entry; pause never stops self-timed work.
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= ST_STANDBY;
         timer_q <= '0;
      end else begin
         case (state_q)
            ST_STANDBY: begin
               if (cs_rise && !paused_q && aligned && opcode_q == OP_SLEEP
                  && !busy_in) begin
                  state_q <= ST_ENTERING;
                  timer_q <= ENTRY_LOAD;
               end
            end
            ST_ENTERING: begin
               if (timer_q == '0) begin
                  state_q <= ST_SLEEP;
               end else begin
                  timer_q <= timer_q - TIMER_W'(1);
               end
            end
            ST_SLEEP: begin
               if (cs_rise && !paused_q && aligned
                  && opcode_q == OP_WAKE) begin
                  state_q <= ST_WAKING;
                  timer_q <= EXIT_LOAD;
               end
            end
            ST_WAKING: begin
               if (timer_q == '0) begin
                  state_q <= ST_STANDBY;
               end else begin
                  timer_q <= timer_q - TIMER_W'(1);
               end
            end
            default: state_q <= ST_STANDBY;
         endcase
      end
   end

   // Visible sleep flag follows the settled state
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         deep_sleep_out <= 1'b0;
      end else begin
         deep_sleep_out <= (state_q == ST_SLEEP) || (state_q == ST_WAKING)
            || (state_q == ST_ENTERING && timer_q == '0);
      end
   end

   // Output launched on SCK fall; floated while paused or asleep
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         so_out <= 1'b0;
         so_oe_out <= 1'b0;
      end else begin
         so_oe_out <= cs_act && !paused_d && !asleep && byte_seen_q;
         if (sck_fall && cs_act && !paused_q) begin
            so_out <= so_data_in;
         end
      end
   end

   // Protect pin and pause flag stay live regardless of pause
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wp_b_out <= 1'b1;
         paused_out <= 1'b0;
      end else begin
         wp_b_out <= wp_s;
         paused_out <= paused_d;
      end
   end

   localparam int ENTRY_MAX = SLEEP_ENTRY_CYCLES + 1;
   localparam int EXIT_MAX = SLEEP_EXIT_CYCLES + 1;

   sequence sleep_go;
      state_q == ST_STANDBY ##1 state_q == ST_ENTERING;
   endsequence
   sequence wake_go;
      state_q == ST_SLEEP ##1 state_q == ST_WAKING;
   endsequence

   a_sleep_entry: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      sleep_go |-> ##[1:ENTRY_MAX] deep_sleep_out)
      else $error("sleep not entered in time");
   a_wake_exit: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      wake_go |-> ##[1:EXIT_MAX] state_q == ST_STANDBY)
      else $error("wake not completed in time");
   a_sleep_ignore: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_q == ST_SLEEP) |=> !cmd_valid_out)
      else $error("command passed while asleep");
   a_short_sleep: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_q == ST_STANDBY && cs_rise && bit_cnt_q != 3'h0)
      |=> state_q == ST_STANDBY)
      else $error("unaligned sleep accepted");
   a_short_wake: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_q == ST_SLEEP && cs_rise && bit_cnt_q != 3'h0)
      |=> state_q == ST_SLEEP)
      else $error("unaligned wake accepted");
   a_busy_block: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (state_q == ST_STANDBY && cs_rise && busy_in)
      |=> state_q == ST_STANDBY)
      else $error("sleep taken while busy");
   a_pause_float: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      paused_q |-> !so_oe_out)
      else $error("output driven while paused");
   a_pause_select: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      !cs_act |=> !paused_q)
      else $error("paused while deselected");
   a_pause_abort: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (cs_rise && paused_q) |=> abort_out && write_enable_latch_clr_out)
      else $error("abort missing on paused release");
   a_launch_fall: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      $changed(so_out) |-> $past(sck_fall))
      else $error("output changed off a falling edge");
   a_pause_high: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (cs_act && sck_s && $past(cs_act)) |-> paused_d == paused_q)
      else $error("pause moved during SCK high");
endmodule : serial_flash_sleep_pause_ctrl

/* common/flash_sleep_pkg.sv */
// Constants for the serial flash sleep and pause control block.
// Assumes a 125 MHz system clock sampling all serial pins.
package flash_sleep_pkg;
   localparam int CLK_FREQ_MHZ = 125;
   // Opcodes that steer the power state
   localparam logic [7:0] OP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_WAKE = 8'hab;
   localparam logic [2:0] BYTE_BOUNDARY = 3'h0;
   // Longest entry and exit times; figures not given, plain defaults
   localparam int SLEEP_ENTRY_TIME_NS = 1000;
   localparam int SLEEP_EXIT_TIME_NS = 1000;
   // Longest times round down, never below one cycle
   localparam int SLEEP_ENTRY_CYCLES_RAW =
      SLEEP_ENTRY_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int SLEEP_EXIT_CYCLES_RAW =
      SLEEP_EXIT_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int SLEEP_ENTRY_CYCLES =
      (SLEEP_ENTRY_CYCLES_RAW < 1) ? 1 : SLEEP_ENTRY_CYCLES_RAW;
   localparam int SLEEP_EXIT_CYCLES =
      (SLEEP_EXIT_CYCLES_RAW < 1) ? 1 : SLEEP_EXIT_CYCLES_RAW;
   localparam int TIMER_W = 12;
   localparam logic [TIMER_W-1:0] ENTRY_LOAD =
      TIMER_W'(SLEEP_ENTRY_CYCLES - 1);
   localparam logic [TIMER_W-1:0] EXIT_LOAD =
      TIMER_W'(SLEEP_EXIT_CYCLES - 1);
   localparam int SYNC_W = 5;
   typedef enum logic [1:0] {
      ST_STANDBY,
      ST_ENTERING,
      ST_SLEEP,
      ST_WAKING
   } power_state_type;
endpackage : flash_sleep_pkg

/* hw/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are independent levels; no bus coherence is needed.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync

/* dv/spi_host_model.sv */
// SPI host model: drives select, SCK and SI, samples SO a full cycle late.
// Assumes its tasks are entered on a sys clock falling edge.
`timescale 1ns/1ps
module spi_host_model (
   input wire logic so_in,
   input wire logic so_oe_in,
   output logic cs_b_out,
   output logic sck_out,
   output logic si_out,
   output logic [7:0] rx_out
);
   // Half-cycle capture, as a plain mode 0 host would take it
   logic [7:0] rx_half;
   // Idle: deselected, SCK parked low
   initial begin
      cs_b_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
      rx_out = 8'h00;
      rx_half = 8'h00;
   end
   task automatic half(input logic lvl);
      #40 sck_out = lvl;
   endtask : half
   // Launch one beat after the rise; the device's synchroniser needs hold
   task automatic clk_bit(input logic nxt);
      #40 sck_out = 1'b1;
      rx_half = {rx_half[6:0], so_oe_in ? so_in : 1'bx};
      #8 si_out = nxt;
      #32 rx_out = {rx_out[6:0], so_oe_in ? so_in : 1'bx};
      sck_out = 1'b0;
   endtask : clk_bit
   // Select stays high a while first, so frames never run together
   task automatic begin_frame(input logic b);
      #40 cs_b_out = 1'b0;
      si_out = b;
   endtask : begin_frame
   // Released data line shows the inverse, never a stale level
   task automatic end_frame();
      #40 cs_b_out = 1'b1;
      si_out = ~si_out;
   endtask : end_frame
   task automatic frame(input logic [15:0] d, input int n);
      begin_frame(d[15]);
      for (int i = 1; i <= n; i++) begin
         clk_bit(i < n ? d[15-i] : d[16-i]);
      end
      end_frame();
   endtask : frame
endmodule : spi_host_model

/* dv/serial_flash_sleep_pause_ctrl_bench.sv */
// Bench for the sleep and pause block, with the host model on its pins.
// Assumes the package timings give entry and exit of 125 cycles.
`timescale 1ns/1ps
module serial_flash_sleep_pause_ctrl_bench;
   import flash_sleep_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   localparam logic [7:0] SO_START = 8'h5a;
   logic busy_in;
   logic pause_b_in;
   logic wp_b_in;
   // Core data is a rotating pattern so every output bit is checked
   logic [7:0] so_pat = SO_START;
   logic so_data_in = 1'b0;
   logic cs_b, sck, si, so, so_oe, sleep, paused, valid, abort, wclr, wp_b;
   logic [7:0] cmd_byte, rx;
   int fails = 0;
   int check_count = 0;
   int valid_seen = 0;
   int abort_seen = 0;
   int c;
   always #4 sys_clk_in = ~sys_clk_in;
   serial_flash_sleep_pause_ctrl i_dut (.sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sck_in(sck), .si_in(si),
      .pause_b_in(pause_b_in), .wp_b_in(wp_b_in), .busy_in(busy_in),
      .so_data_in(so_data_in), .so_out(so), .so_oe_out(so_oe),
      .deep_sleep_out(sleep), .paused_out(paused), .cmd_byte_out(cmd_byte),
      .cmd_valid_out(valid), .abort_out(abort),
      .write_enable_latch_clr_out(wclr), .wp_b_out(wp_b));
   spi_host_model i_host (.so_in(so), .so_oe_in(so_oe), .cs_b_out(cs_b),
      .sck_out(sck), .si_out(si), .rx_out(rx));
   // Next core bit moves on each host SCK fall, as a core would supply it
   always @(negedge sck) begin
      if (rst_b_in) begin
         so_pat = {so_pat[6:0], so_pat[7]};
         so_data_in = so_pat[7];
      end
   end
   // Pulse counters, read mid-cycle away from the launching edge;
   // abort only counts when the latch clear pulses with it
   always @(negedge sys_clk_in) begin
      if (valid === 1'b1) valid_seen++;
      if (abort === 1'b1 && wclr === 1'b1) abort_seen++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : cyc
   // Bounded wait for the sleep flag; 400 cycles covers either timer
   task automatic wait_sleep(input logic lvl);
      c = 0;
      while (sleep !== lvl && c < 400) begin
         cyc(1);
         c++;
      end
   endtask : wait_sleep
   task automatic t_cmd();
      valid_seen = 0;
      i_host.frame(16'h9f00, 16);
      cyc(4);
      check(valid_seen, 1);
      check(cmd_byte, 8'h9f);
      check(rx, SO_START);
      check(i_host.rx_half, SO_START);
   endtask : t_cmd
   task automatic t_refused();
      busy_in = 1'b1;
      i_host.frame(16'hb900, 8);
      cyc(20);
      busy_in = 1'b0;
      wait_sleep(1'b1);
      check(sleep, 0);
      i_host.frame(16'hb900, 7);
      wait_sleep(1'b1);
      check(sleep, 0);
      i_host.frame(16'hb900, 12);
      wait_sleep(1'b1);
      check(sleep, 0);
   endtask : t_refused
   task automatic t_sleep_wake();
      i_host.frame(16'hb9ab, 16);
      wait_sleep(1'b1);
      check(c >= SLEEP_ENTRY_CYCLES && c <= SLEEP_ENTRY_CYCLES + 8, 1);
      valid_seen = 0;
      i_host.frame(16'h9f00, 8);
      i_host.frame(16'hab00, 7);
      wait_sleep(1'b0);
      i_host.frame(16'hab00, 12);
      wait_sleep(1'b0);
      check(valid_seen, 0);
      check(sleep, 1);
      i_host.frame(16'habff, 16);
      wait_sleep(1'b0);
      check(c >= SLEEP_EXIT_CYCLES && c <= SLEEP_EXIT_CYCLES + 8, 1);
   endtask : t_sleep_wake
   // Pause in byte two; edges clocked while paused must not count
   task automatic t_pause();
      i_host.begin_frame(1'b1);
      for (int i = 1; i < 12; i++) begin
         i_host.clk_bit(i == 2 || i == 3 || i == 4 || i == 7);
      end
      i_host.half(1'b1);
      pause_b_in = 1'b0;
      cyc(10);
      check(paused, 0);
      i_host.half(1'b0);
      cyc(6);
      check(paused, 1);
      check(so_oe, 0);
      wp_b_in = 1'b0;
      cyc(6);
      check(wp_b, 0);
      wp_b_in = 1'b1;
      i_host.half(1'b1);
      i_host.half(1'b0);
      i_host.half(1'b1);
      pause_b_in = 1'b1;
      cyc(6);
      check(paused, 1);
      i_host.half(1'b0);
      cyc(6);
      check(paused, 0);
      for (int i = 12; i < 16; i++) i_host.clk_bit(1'b0);
      i_host.end_frame();
      wait_sleep(1'b1);
      check(sleep, 1);
      i_host.frame(16'hab00, 8);
      wait_sleep(1'b0);
   endtask : t_pause
   task automatic t_abort();
      abort_seen = 0;
      i_host.begin_frame(1'b0);
      for (int i = 1; i < 5; i++) i_host.clk_bit(1'b1);
      pause_b_in = 1'b0;
      cyc(6);
      check(paused, 1);
      i_host.end_frame();
      cyc(8);
      check(abort_seen, 1);
      check(paused, 0);
      pause_b_in = 1'b1;
      cyc(8);
   endtask : t_abort
   task automatic finish_test();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // Watchdog well past the expected run of about 32 us
   initial begin
      #200000;
      fails++;
      finish_test();
   end
   initial begin
      busy_in = 1'b0;
      pause_b_in = 1'b1;
      wp_b_in = 1'b1;
      cyc(8);
      rst_b_in = 1'b1;
      cyc(4);
      check(sleep, 0);
      check(paused, 0);
      check(wp_b, 1);
      check(so_oe, 0);
      t_cmd();
      t_refused();
      t_sleep_wake();
      t_pause();
      t_abort();
      finish_test();
   end
endmodule : serial_flash_sleep_pause_ctrl_bench
